// ==== logic/ad_pkg.sv ====
package ad_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h010;
  localparam logic [11:0] ADDR_PLAY_NEXT = 12'h014;
  localparam logic [11:0] ADDR_REC_NEXT = 12'h018;
  localparam logic [11:0] ADDR_REC_CUR = 12'h01c;
  localparam logic [11:0] ADDR_STATUS = 12'h020;

  // Status field positions
  localparam int STAT_IE_BIT = 31;
  localparam int STAT_PN_BIT = 9;
  localparam int STAT_PC_BIT = 8;
  localparam int STAT_RN_BIT = 1;
  localparam int STAT_RC_BIT = 0;

  // Control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STEREO_BIT = 1;
  localparam int CTRL_LINEAR_BIT = 2;

  // Page geometry
  localparam int PAGE_OFS_BITS = 12;
  localparam logic [11:0] PAGE_LAST_WORD = 12'hffc;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // Reset values
  localparam logic PN_RESET = 1'b1;
  localparam logic PC_RESET = 1'b0;
  localparam logic RN_RESET = 1'b1;
  localparam logic RC_RESET = 1'b0;
  localparam logic IE_RESET = 1'b0;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } ad_smp_t;

  typedef struct packed {
    logic stereo;
    logic linear;
  } ad_fmt_t;

  typedef enum logic [1:0] {
    MEM_IDLE = 2'b00,
    MEM_WRITE = 2'b01,
    MEM_READ = 2'b10
  } ad_mem_state_t;

endpackage : ad_pkg

// ==== logic/ad_sample_packer.sv ====
module ad_sample_packer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire ad_pkg::ad_fmt_t fmt,
  input wire logic clear,
  // Sample side
  input wire logic smp_valid,
  input wire ad_pkg::ad_smp_t smp,
  output logic smp_ready,
  // Word side
  output logic word_valid,
  output logic [31:0] word,
  input wire logic word_ready
);
  logic [31:0] word_reg;
  logic [2:0] fill_reg;
  logic full_reg;
  logic [2:0] nb;
  logic accept;

  always_comb begin
    case ({fmt.linear, fmt.stereo})
      2'b00: nb = 3'd1;
      2'b11: nb = 3'd4;
      default: nb = 3'd2;
    endcase
  end

  assign smp_ready = !full_reg;
  assign word_valid = full_reg;
  assign word = word_reg;
  assign accept = smp_valid && smp_ready;

  // Shifting left keeps the earliest sample in the top lanes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 32'h0000_0000;
      fill_reg <= 3'd0;
      full_reg <= 1'b0;
    end else if (clear) begin
      fill_reg <= 3'd0;
      full_reg <= 1'b0;
    end else if (word_valid && word_ready) begin
      fill_reg <= 3'd0;
      full_reg <= 1'b0;
    end else if (accept) begin
      case ({fmt.linear, fmt.stereo})
        2'b00: word_reg <= {word_reg[23:0], smp.left[7:0]};
        2'b01: word_reg <= {word_reg[15:0], smp.left[7:0], smp.right[7:0]};
        2'b10: word_reg <= {word_reg[15:0], smp.left};
        default: word_reg <= {smp.left, smp.right};
      endcase
      fill_reg <= fill_reg + nb;
      full_reg <= (fill_reg + nb) == 3'd4;
    end
  end

  st16_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && !clear && fmt.linear && fmt.stereo |=> word_valid && word == $past(smp))
    else $error("16-bit stereo sample not packed left above right");

  mono8_cov: cover property (@(posedge clk) disable iff (!rst_n)
    !fmt.linear && !fmt.stereo && word_valid);

endmodule : ad_sample_packer

// ==== logic/ad_sample_unpacker.sv ====
module ad_sample_unpacker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire ad_pkg::ad_fmt_t fmt,
  input wire logic clear,
  // Word side
  input wire logic word_valid,
  input wire logic [31:0] word,
  output logic word_ready,
  // Sample side
  output logic smp_valid,
  output ad_pkg::ad_smp_t smp,
  input wire logic smp_ready
);
  logic [31:0] word_reg;
  logic [2:0] left_reg;

  assign word_ready = left_reg == 3'd0;
  assign smp_valid = left_reg != 3'd0;

  // 8-bit codes sit in the low byte of each lane; mono repeats on both lanes
  always_comb begin
    case ({fmt.linear, fmt.stereo})
      2'b00: smp = '{left: {8'h00, word_reg[31:24]}, right: {8'h00, word_reg[31:24]}};
      2'b01: smp = '{left: {8'h00, word_reg[31:24]}, right: {8'h00, word_reg[23:16]}};
      2'b10: smp = '{left: word_reg[31:16], right: word_reg[31:16]};
      default: smp = '{left: word_reg[31:16], right: word_reg[15:0]};
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 32'h0000_0000;
      left_reg <= 3'd0;
    end else if (clear) begin
      left_reg <= 3'd0;
    end else if (word_valid && word_ready) begin
      word_reg <= word;
      left_reg <= 3'd4;
    end else if (smp_valid && smp_ready) begin
      case ({fmt.linear, fmt.stereo})
        2'b00: begin
          word_reg <= {word_reg[23:0], 8'h00};
          left_reg <= left_reg - 3'd1;
        end
        2'b11: begin
          left_reg <= 3'd0;
        end
        default: begin
          word_reg <= {word_reg[15:0], 16'h0000};
          left_reg <= (left_reg > 3'd2) ? 3'd2 : 3'd0;
        end
      endcase
    end
  end

endmodule : ad_sample_unpacker

// ==== logic/ad_dma_core.sv ====
// Local design decision: register access over APB.
module ad_dma_core (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // Memory write port
  output logic MEM_WR_REQ,
  output logic [31:0] MEM_WR_ADDR,
  output logic [31:0] MEM_WR_DATA,
  input wire logic MEM_WR_ACK,
  // Memory read port
  output logic MEM_RD_REQ,
  output logic [31:0] MEM_RD_ADDR,
  input wire logic [31:0] MEM_RD_DATA,
  input wire logic MEM_RD_ACK,
  // Record samples from codec
  input wire logic REC_SMP_VALID,
  input wire ad_pkg::ad_smp_t REC_SMP,
  output logic REC_SMP_READY,
  // Playback samples to codec
  output logic PLY_SMP_VALID,
  output ad_pkg::ad_smp_t PLY_SMP,
  input wire logic PLY_SMP_READY
);

  logic [2:0] ctrl_reg;
  logic run_q_reg;
  logic [31:0] play_next_reg;
  logic [31:0] rec_next_reg;
  logic [31:0] play_cur_reg;
  logic [31:0] rec_cur_reg;
  logic ie_reg;
  logic pn_reg;
  logic pc_reg;
  logic rn_reg;
  logic rc_reg;
  logic [31:0] prdata_reg;
  ad_pkg::ad_mem_state_t state_reg;
  ad_pkg::ad_mem_state_t state_next;

  logic run;
  logic start;
  logic stopped;
  ad_pkg::ad_fmt_t fmt;
  logic wr_access;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_play_next;
  logic wr_rec_next;
  logic wr_rec_cur;
  logic wr_status;
  logic rec_done;
  logic play_done;
  logic rec_wrap;
  logic play_wrap;
  logic pk_word_valid;
  logic [31:0] pk_word;
  logic up_word_ready;
  logic up_smp_valid;
  logic [31:0] page_mask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign run = ctrl_reg[ad_pkg::CTRL_RUN_BIT];
  assign fmt = '{stereo: ctrl_reg[ad_pkg::CTRL_STEREO_BIT], linear: ctrl_reg[ad_pkg::CTRL_LINEAR_BIT]};
  assign start = run && !run_q_reg;
  assign stopped = !run && state_reg == ad_pkg::MEM_IDLE;

  // APB decode; zero wait states, so writes land on the access edge
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wr_ctrl = wr_access && PADDR == ad_pkg::ADDR_CTRL;
  assign wr_play_next = wr_access && PADDR == ad_pkg::ADDR_PLAY_NEXT;
  assign wr_rec_next = wr_access && PADDR == ad_pkg::ADDR_REC_NEXT;
  assign wr_rec_cur = wr_access && PADDR == ad_pkg::ADDR_REC_CUR;
  assign wr_status = wr_access && PADDR == ad_pkg::ADDR_STATUS;

  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      ad_pkg::ADDR_CTRL: rd_mux = {29'h0000_0000, ctrl_reg};
      ad_pkg::ADDR_PLAY_NEXT: rd_mux = play_next_reg;
      ad_pkg::ADDR_REC_NEXT: rd_mux = rec_next_reg;
      ad_pkg::ADDR_REC_CUR: rd_mux = rec_cur_reg;
      ad_pkg::ADDR_STATUS: rd_mux = {ie_reg, 21'h00_0000, pn_reg, pc_reg, 6'h00, rn_reg, rc_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_reg;

  // Whole word snapped in one cycle, so a single read is coherent
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= 3'b000;
      run_q_reg <= 1'b0;
    end else begin
      run_q_reg <= run;
      if (wr_ctrl && PSTRB[0]) begin
        ctrl_reg <= PWDATA[2:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ie_reg <= ad_pkg::IE_RESET;
    end else if (wr_status && PSTRB[3]) begin
      ie_reg <= PWDATA[ad_pkg::STAT_IE_BIT];
    end
  end

  // Next-page registers hold page bases only
  assign page_mask = {{(32 - ad_pkg::PAGE_OFS_BITS){1'b1}}, {ad_pkg::PAGE_OFS_BITS{1'b0}}};

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      play_next_reg <= ad_pkg::PTR_RESET;
      rec_next_reg <= ad_pkg::PTR_RESET;
    end else begin
      if (wr_play_next) begin
        play_next_reg <= merge(play_next_reg, PWDATA, PSTRB) & page_mask;
      end
      if (wr_rec_next) begin
        rec_next_reg <= merge(rec_next_reg, PWDATA, PSTRB) & page_mask;
      end
    end
  end

  // Memory sequencer; record has priority so the codec never overruns
  assign rec_done = state_reg == ad_pkg::MEM_WRITE && MEM_WR_ACK;
  assign play_done = state_reg == ad_pkg::MEM_READ && MEM_RD_ACK;
  assign rec_wrap = rec_done && rec_cur_reg[11:0] == ad_pkg::PAGE_LAST_WORD;
  assign play_wrap = play_done && play_cur_reg[11:0] == ad_pkg::PAGE_LAST_WORD;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ad_pkg::MEM_IDLE: begin
        if (run && !start && pk_word_valid) begin
          state_next = ad_pkg::MEM_WRITE;
        end else if (run && !start && up_word_ready) begin
          state_next = ad_pkg::MEM_READ;
        end
      end
      ad_pkg::MEM_WRITE: begin
        if (MEM_WR_ACK) begin
          state_next = ad_pkg::MEM_IDLE;
        end
      end
      ad_pkg::MEM_READ: begin
        if (MEM_RD_ACK) begin
          state_next = ad_pkg::MEM_IDLE;
        end
      end
      default: state_next = ad_pkg::MEM_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ad_pkg::MEM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign MEM_WR_REQ = state_reg == ad_pkg::MEM_WRITE;
  assign MEM_RD_REQ = state_reg == ad_pkg::MEM_READ;
  assign MEM_WR_ADDR = {rec_cur_reg[31:2], 2'b00};
  assign MEM_RD_ADDR = {play_cur_reg[31:2], 2'b00};
  assign MEM_WR_DATA = pk_word;

  // A test write to the current pointer overrides the sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rec_cur_reg <= ad_pkg::PTR_RESET;
    end else if (wr_rec_cur) begin
      rec_cur_reg <= merge(rec_cur_reg, PWDATA, PSTRB);
    end else if (start || rec_wrap) begin
      rec_cur_reg <= rec_next_reg;
    end else if (rec_done) begin
      rec_cur_reg <= rec_cur_reg + ad_pkg::WORD_STEP;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      play_cur_reg <= ad_pkg::PTR_RESET;
    end else if (start || play_wrap) begin
      play_cur_reg <= play_next_reg;
    end else if (play_done) begin
      play_cur_reg <= play_cur_reg + ad_pkg::WORD_STEP;
    end
  end

  // Set beats clear when a page ends on the same edge as the write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pn_reg <= ad_pkg::PN_RESET;
    end else if (start || play_wrap) begin
      pn_reg <= 1'b1;
    end else if (wr_play_next) begin
      pn_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rn_reg <= ad_pkg::RN_RESET;
    end else if (start || rec_wrap) begin
      rn_reg <= 1'b1;
    end else if (wr_rec_next) begin
      rn_reg <= 1'b0;
    end
  end

  // Both directions share one run bit, so the active flags move together
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_reg <= ad_pkg::PC_RESET;
      rc_reg <= ad_pkg::RC_RESET;
    end else if (start) begin
      pc_reg <= 1'b1;
      rc_reg <= 1'b1;
    end else if (stopped) begin
      pc_reg <= 1'b0;
      rc_reg <= 1'b0;
    end
  end

  // Either request is enough, so a late record request interrupts again
  assign IRQ = ie_reg && (pn_reg || rn_reg);

  // Partial words are dropped on stop; samples are moved as raw two's complement
  ad_sample_packer u_packer (
    .clk(CLK),
    .rst_n(ARST_N),
    .fmt(fmt),
    .clear(!run),
    .smp_valid(REC_SMP_VALID),
    .smp(REC_SMP),
    .smp_ready(REC_SMP_READY),
    .word_valid(pk_word_valid),
    .word(pk_word),
    .word_ready(rec_done)
  );

  ad_sample_unpacker u_unpacker (
    .clk(CLK),
    .rst_n(ARST_N),
    .fmt(fmt),
    .clear(!run),
    .word_valid(play_done),
    .word(MEM_RD_DATA),
    .word_ready(up_word_ready),
    .smp_valid(up_smp_valid),
    .smp(PLY_SMP),
    .smp_ready(PLY_SMP_READY)
  );

  assign PLY_SMP_VALID = up_smp_valid && run;

  rec_next_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_rec_next |=> rec_next_reg[11:0] == 12'h000)
    else $error("record next page low bits not zero");

  rec_adv_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    rec_done && !rec_wrap && !wr_rec_cur && !start |=> rec_cur_reg == $past(rec_cur_reg) + 32'h0000_0004)
    else $error("record pointer did not advance one word");

  rec_wrap_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    rec_wrap && !wr_rec_cur |=> rec_cur_reg == $past(rec_next_reg) && rn_reg)
    else $error("record page end did not load next page");

  pn_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_play_next && !play_wrap && !start |=> !pn_reg ##1 (pn_reg == $past(play_wrap || start)))
    else $error("playback request not cleared by write");

  rn_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_rec_next && !rec_wrap && !start |=> !rn_reg)
    else $error("record request not cleared by write");

  active_pair_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(run) |=> rc_reg && pc_reg && rn_reg && pn_reg)
    else $error("start did not raise active and request flags");

  active_stop_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !run && !MEM_WR_REQ && !MEM_RD_REQ |=> !rc_reg && !pc_reg)
    else $error("active flags linger after stop");

  irq_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $fell(ie_reg) |-> !IRQ)
    else $error("interrupt not gated by enable");

  irq_late_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ie_reg && !pn_reg && $rose(rn_reg) |-> IRQ)
    else $error("late record request gave no interrupt");

  word_align_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    MEM_WR_REQ && !MEM_WR_ACK |=> MEM_WR_REQ && MEM_WR_ADDR[1:0] == 2'b00 && $stable(MEM_WR_DATA))
    else $error("memory write not held or unaligned");

  rec_wrap_c: cover property (@(posedge CLK) disable iff (!ARST_N) rec_wrap);
  play_wrap_c: cover property (@(posedge CLK) disable iff (!ARST_N) play_wrap);
  irq_rise_c: cover property (@(posedge CLK) disable iff (!ARST_N) $rose(IRQ));
  set_clear_c: cover property (@(posedge CLK) disable iff (!ARST_N) rec_wrap && wr_rec_next);

endmodule : ad_dma_core

// ==== bench/ad_mem_model.sv ====
module ad_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Answer delay in cycles
  input wire logic [3:0] dly,
  // Write port
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  output logic wr_ack,
  // Read port
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic [31:0] rd_data,
  output logic rd_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg;
  logic [31:0] log_addr [16];
  logic [31:0] log_data [16];
  int n_wr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
      wr_ack <= 1'b0;
      rd_ack <= 1'b0;
      rd_data <= 32'h0;
      n_wr <= 0;
    end else begin
      wr_ack <= 1'b0;
      rd_ack <= 1'b0;
      // Outside an answer the read bus toggles each cycle between the last word and its inverse
      rd_data <= ~rd_data;
      if (wr_ack || rd_ack) begin
        wait_reg <= 4'h0;
      end else if (wr_req || rd_req) begin
        if (wait_reg == dly) begin
          wr_ack <= wr_req;
          rd_ack <= !wr_req;
          if (wr_req) begin
            log_addr[n_wr % 16] <= wr_addr;
            log_data[n_wr % 16] <= wr_data;
            n_wr <= n_wr + 1;
          end else begin
            rd_data <= rd_addr ^ 32'h5a5a_0000;
          end
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule : ad_mem_model

// ==== bench/ad_dma_core_tb.sv ====
module ad_dma_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic mwr_req;
  logic mwr_ack;
  logic mrd_req;
  logic mrd_ack;
  logic [31:0] mwr_addr;
  logic [31:0] mwr_data;
  logic [31:0] mrd_addr;
  logic [31:0] mrd_data;
  logic rsv = 1'b0;
  ad_pkg::ad_smp_t rs = 32'h0;
  logic rsr;
  logic pv;
  ad_pkg::ad_smp_t ps;
  logic pr = 1'b1;
  logic [3:0] dly = 4'h0;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] base;
  logic [31:0] s;
  logic [31:0] m;
  int k;
  int n;
  int sz;
  int lw;
  localparam logic [31:0] EXPW [4] = '{32'h8102_8304, 32'ha1b2_c3d4, 32'h8001_7ffe, 32'hfedc_1234};

  ad_dma_core i_ad_dma_core (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .MEM_WR_REQ(mwr_req), .MEM_WR_ADDR(mwr_addr), .MEM_WR_DATA(mwr_data), .MEM_WR_ACK(mwr_ack),
    .MEM_RD_REQ(mrd_req), .MEM_RD_ADDR(mrd_addr), .MEM_RD_DATA(mrd_data), .MEM_RD_ACK(mrd_ack),
    .REC_SMP_VALID(rsv), .REC_SMP(rs), .REC_SMP_READY(rsr), .PLY_SMP_VALID(pv), .PLY_SMP(ps),
    .PLY_SMP_READY(pr));
  ad_mem_model i_ad_mem_model (.clk(clk), .rst_n(arst_n), .dly(dly), .wr_req(mwr_req), .wr_addr(mwr_addr),
    .wr_data(mwr_data), .wr_ack(mwr_ack), .rd_req(mrd_req), .rd_addr(mrd_addr), .rd_data(mrd_data),
    .rd_ack(mrd_ack));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic smp(input logic [15:0] l, input logic [15:0] r);
    int c;
    c = 0;
    @(posedge clk);
    rsv <= 1'b1;
    rs <= {l, r};
    do begin
      @(posedge clk);
      c++;
    end while (rsr !== 1'b1 && c < 50);
    if (rsr !== 1'b1) fail_count++;
    rsv <= 1'b0;
  endtask : smp

  task automatic wait_wr(input int after);
    int c;
    c = 0;
    while (i_ad_mem_model.n_wr <= after && c < 300) begin
      @(posedge clk);
      c++;
    end
    chk(32'(i_ad_mem_model.n_wr), 32'(after + 1));
  endtask : wait_wr

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rchk(ad_pkg::ADDR_STATUS, 32'h0000_0202);
    rchk(ad_pkg::ADDR_REC_CUR, ad_pkg::PTR_RESET);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ad_pkg::ADDR_STATUS, 32'hffff_ffff);
    rchk(ad_pkg::ADDR_STATUS, 32'h8000_0202);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ad_pkg::ADDR_PLAY_NEXT, 32'h0000_3abc);
    rchk(ad_pkg::ADDR_STATUS, 32'h8000_0002);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ad_pkg::ADDR_REC_NEXT, 32'h0000_1fff);
    rchk(ad_pkg::ADDR_STATUS, 32'h8000_0000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ad_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      base = 32'((f + 1) << 12);
      if (f > 0) begin
        apb(1'b1, ad_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, ad_pkg::ADDR_PLAY_NEXT, base | 32'h0000_0fff);
        apb(1'b1, ad_pkg::ADDR_REC_NEXT, base | 32'h0000_0fff);
      end
      dly <= 4'(f);
      // Stall playback in stereo runs so writes compete with a full unpacker
      pr <= ~f[0];
      apb(1'b1, ad_pkg::ADDR_CTRL, {29'h0, f[1], f[0], 1'b1});
      rchk(ad_pkg::ADDR_STATUS, 32'h0000_0303);
      rchk(ad_pkg::ADDR_REC_CUR, base);
      k = i_ad_mem_model.n_wr;
      sz = 8 * (1 + f[0]) * (1 + f[1]);
      lw = 8 << f[1];
      m = (32'h1 << lw) - 32'h1;
      for (int i = 0; i < 32 / sz; i++) begin
        s = EXPW[f] >> (32 - sz * (i + 1));
        // Upper byte of an 8-bit lane is filler the packer must drop
        if (f[0]) smp(16'((s >> lw) & m) | (lw == 8 ? 16'h5500 : 16'h0), 16'(s & m) | (lw == 8 ? 16'h5500 : 16'h0));
        else smp(16'(s & m) | (lw == 8 ? 16'h5500 : 16'h0), 16'h0a0a);
      end
      wait_wr(k);
      chk(i_ad_mem_model.log_data[k % 16], EXPW[f]);
      chk(i_ad_mem_model.log_addr[k % 16], base);
      // Stalled playback still shows the first word read from the page
      if (f[0]) begin
        chk({31'h0, pv}, 32'h1);
        chk(ps, f[1] ? (base ^ 32'h5a5a_0000) : 32'h005a_005a);
      end
      rchk(ad_pkg::ADDR_REC_CUR, base + ad_pkg::WORD_STEP);
      $display("test format %0d done", f);
    end
    apb(1'b1, ad_pkg::ADDR_REC_NEXT, 32'h0009_0abc);
    rchk(ad_pkg::ADDR_STATUS, 32'h0000_0301);
    apb(1'b1, ad_pkg::ADDR_REC_CUR, 32'h0002_0ffc);
    k = i_ad_mem_model.n_wr;
    smp(16'h0001, 16'hffff);
    wait_wr(k);
    chk(i_ad_mem_model.log_addr[k % 16], 32'h0002_0ffc);
    chk(i_ad_mem_model.log_data[k % 16], 32'h0001_ffff);
    rchk(ad_pkg::ADDR_REC_CUR, 32'h0009_0000);
    rchk(ad_pkg::ADDR_STATUS, 32'h0000_0303);
    $display("test page end done");
    apb(1'b1, ad_pkg::ADDR_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, ad_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk(rd & 32'h0000_0101, 32'h0);
    $display("test stop done");
    give_verdict;
  end
endmodule : ad_dma_core_tb
